// File: verilog/bod_pkg.sv
// constants, types and field layouts for the byte-op and branch decoder
//
// Overview of operation
// RULE1: access bit 0 uses the access-bank map; 1 takes the bank from bank_select_reg.
// RULE2: destination bit 0 writes working_reg; 1 writes the addressed file register.
// RULE3: file field is an 8-bit address 00h-FFh, or a pointer number 0h-3h.
// RULE4: and_work_with_file ANDs working_reg with the file, updating only N and Z.
// RULE5: branch_if_carry_set loads PC+2+2n when carry; one cycle, two if taken.
// RULE6: relative offsets are two's complement; absolute branches take a direct address.
// RULE7: fast bit 0 leaves shadows alone; 1 saves to or restores from them.
// RULE8: table mode selects none, post-inc, post-dec or pre-inc; data via table_latch.
// RULE9: memory moves decode separate 12-bit source and destination addresses 000h-FFFh.
// RULE10: literal fields are 8, 12 or 20 bits wide depending on instruction.
// RULE11: indexed moves use separate 7-bit source and destination offsets.
// RULE12: bit instructions use a 3-bit field choosing bit 0 to bit 7.
// RULE13: status keeps carry, digit carry, zero, overflow and negative flags.
// RULE14: a taken branch runs a no-operation cycle before fetching the new pc.
package bod_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_WORK   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BANK   = 8'h08;
  localparam logic [7:0] OFS_TABLE_POINTER = 8'h0c;
  localparam logic [7:0] OFS_PC     = 8'h10;
  localparam logic [7:0] OFS_TBLLAT = 8'h14;

  // ----------------------------------------
  // reset values and decode constants
  // ----------------------------------------
  localparam logic [20:0] PC_RESET     = 21'h000000;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  BANK_LOW     = 4'h0;
  localparam logic [3:0]  BANK_SFR     = 4'hf;
  localparam logic [1:0]  TBL_NONE     = 2'h0;
  localparam logic [1:0]  TBL_POSTINC  = 2'h1;
  localparam logic [1:0]  TBL_POSTDEC  = 2'h2;
  localparam logic [1:0]  TBL_PREINC   = 2'h3;

  typedef enum logic [2:0] {
    ST_SEQ    = 3'b000,
    ST_FLUSH  = 3'b001,
    ST_TBL    = 3'b010,
    ST_MOVFF2 = 3'b011,
    ST_MOVSS2 = 3'b100
  } bod_state_t;

  typedef enum logic [1:0] {
    LIT_NONE = 2'b00,
    LIT_8    = 2'b01,
    LIT_12   = 2'b10,
    LIT_20   = 2'b11
  } bod_litw_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } bod_flags_t;

  typedef struct packed {
    logic [11:0] file_addr;
    logic        dest_file;
    logic [2:0]  bit_sel;
    logic [1:0]  fsr_sel;
    logic [19:0] literal;
    bod_litw_t   lit_width;
    logic [1:0]  tbl_mode;
    logic        tbl_read;
    logic        fast_sel;
    logic [6:0]  src_off;
    logic [6:0]  dst_off;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [20:0] target;
  } bod_dec_t;

endpackage

// File: verilog/bod_byte_op_decode.sv
// instruction field decoder with and-with-file, branch on carry and ahb-lite registers
`timescale 1ns/10ps
module bod_byte_op_decode import bod_pkg::*; (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic [31:0] hrdata,
  output      logic        hresp,
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_word,
  input  wire logic [7:0]  prog_data,
  output      logic [20:0] pc,
  output      logic [20:0] table_pointer,
  output      bod_dec_t    decoded,
  output      logic        nop_cycle
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  bod_state_t  state_reg;
  bod_state_t  state_next;
  bod_dec_t    dec_reg;
  bod_dec_t    dec_next;
  bod_flags_t  flags_reg;
  bod_flags_t  shadow_flags_reg;
  logic [7:0]  working_reg_reg;
  logic [7:0]  shadow_work_reg;
  logic [3:0]  bank_select_reg;
  logic [3:0]  shadow_bank_reg;
  logic [20:0] pc_reg;
  logic [20:0] table_pointer_reg;
  logic [7:0]  table_latch_reg;
  logic        nop_reg;
  logic [7:0]  dmem [0:4095];

  // ----------------------------------------
  // instruction classes
  // ----------------------------------------
  logic [15:0] w;
  logic        go_seq;
  logic        go_second;
  logic        is_and_work_with_file;
  logic        is_bc;
  logic        is_bcond;
  logic        is_goto;
  logic        is_tbl;
  logic        is_call;
  logic        is_ret;
  logic        is_movff;
  logic        is_movss;
  logic        is_bit;
  logic        is_lfsr;
  logic        is_lit8;
  logic        bc_taken;
  logic [11:0] addr_now;
  logic [7:0]  file_rd;
  logic [7:0]  and_res;
  logic [20:0] rel_off;

  assign w         = fetch_word;
  assign go_seq    = fetch_valid && (state_reg == ST_SEQ);
  assign go_second = fetch_valid && (state_reg == ST_MOVFF2 || state_reg == ST_MOVSS2);
  assign is_and_work_with_file  = (w[15:10] == 6'h05);
  assign is_bc     = (w[15:8] == 8'he2);
  assign is_bcond  = (w[15:11] == 5'h1c);
  assign is_goto   = (w[15:8] == 8'hef);
  assign is_tbl    = (w[15:4] == 12'h000) && w[3];
  assign is_call   = (w[15:9] == 7'h76);
  assign is_ret    = (w[15:1] == 15'h0009);
  assign is_movff  = (w[15:12] == 4'hc);
  assign is_movss  = (w[15:7] == 9'h1d7);
  assign is_bit    = (w[15:14] == 2'h2);
  assign is_lfsr   = (w[15:6] == 10'h3b8);
  assign is_lit8   = (w[15:11] == 5'h01);
  assign bc_taken  = go_seq && is_bc && flags_reg.c; // [RULE5]
  // two's complement word offset doubled to a byte distance
  assign rel_off   = {{12{w[7]}}, w[7:0], 1'b0}; // [RULE6]

  // a=0 forces the access map and bank_select_reg is not looked at
  always_comb begin
    if (!w[8]) begin // [RULE1]
      addr_now = (w[7:0] < ACCESS_SPLIT) ? {BANK_LOW, w[7:0]} : {BANK_SFR, w[7:0]};
    end else begin
      addr_now = {bank_select_reg, w[7:0]}; // [RULE1]
    end
  end

  assign file_rd = dmem[addr_now]; // [RULE3]
  assign and_res = working_reg_reg & file_rd; // [RULE4]

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  always_comb begin
    dec_next = dec_reg;
    if (go_seq) begin
      dec_next.file_addr = addr_now; // [RULE3]
      dec_next.dest_file = w[9]; // [RULE2]
      dec_next.bit_sel   = w[11:9]; // [RULE12]
      dec_next.fsr_sel   = w[5:4]; // [RULE3]
      dec_next.tbl_mode  = w[1:0]; // [RULE8]
      dec_next.tbl_read  = !w[2];
      // call carries its fast bit in bit 8, return in bit 0
      dec_next.fast_sel  = is_call ? w[8] : w[0]; // [RULE7]
      dec_next.literal   = {12'h000, w[7:0]};
      dec_next.lit_width = LIT_NONE;
      dec_next.target    = pc_reg + PC_STEP;
      if (is_lit8) begin
        dec_next.lit_width = LIT_8; // [RULE10]
      end else if (is_lfsr) begin
        dec_next.literal   = {16'h0000, w[3:0]};
        dec_next.lit_width = LIT_12; // [RULE10]
      end else if (is_goto || is_call) begin
        dec_next.lit_width = LIT_20; // [RULE10]
      end
      if (is_bcond) begin
        dec_next.target = pc_reg + PC_STEP + rel_off; // [RULE6]
      end else if (is_goto) begin
        dec_next.target = {12'h000, w[7:0], 1'b0}; // [RULE6]
      end
      if (is_movff) begin
        dec_next.src_addr = w[11:0]; // [RULE9]
      end
      if (is_movss) begin
        dec_next.src_off = w[6:0]; // [RULE11]
      end
    end else if (go_second) begin
      if (state_reg == ST_MOVFF2) begin
        dec_next.dst_addr = w[11:0]; // [RULE9]
      end else begin
        dec_next.dst_off = w[6:0]; // [RULE11]
      end
    end
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SEQ: begin
        if (bc_taken) begin
          state_next = ST_FLUSH; // [RULE14]
        end else if (go_seq && is_tbl) begin
          state_next = ST_TBL; // [RULE8]
        end else if (go_seq && is_movff) begin
          state_next = ST_MOVFF2;
        end else if (go_seq && is_movss) begin
          state_next = ST_MOVSS2;
        end
      end
      ST_FLUSH: state_next = ST_SEQ;
      ST_TBL: state_next = ST_SEQ;
      ST_MOVFF2: begin
        if (fetch_valid) begin
          state_next = ST_SEQ;
        end
      end
      ST_MOVSS2: begin
        if (fetch_valid) begin
          state_next = ST_SEQ;
        end
      end
      default: state_next = ST_SEQ;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_SEQ;
      nop_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      // dead cycle: prefetched word is ignored and pc holds
      nop_reg   <= (state_next == ST_FLUSH) || (state_next == ST_TBL); // [RULE14]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_reg <= PC_RESET;
    end else if (bc_taken) begin
      pc_reg <= pc_reg + PC_STEP + rel_off; // [RULE5]
    end else if (go_seq || go_second) begin
      pc_reg <= pc_reg + PC_STEP;
    end
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  logic       wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic       addr_ok;
  logic       sw_wr;
  logic [31:0] rd_mux;

  assign addr_ok = hsel && hready && htrans[1];
  assign sw_wr   = wr_pend_reg;

  always_comb begin
    case (haddr[7:0])
      OFS_WORK:   rd_mux = {24'h000000, working_reg_reg};
      OFS_STATUS: rd_mux = {27'h0000000, flags_reg};
      OFS_BANK:   rd_mux = {28'h0000000, bank_select_reg};
      OFS_TABLE_POINTER: rd_mux = {11'h000, table_pointer_reg};
      OFS_PC:     rd_mux = {11'h000, pc_reg};
      OFS_TBLLAT: rd_mux = {24'h000000, table_latch_reg};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  // zero wait states: read data is latched in the address phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr_reg <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        hrdata <= (haddr[31:8] == 24'h000000) ? rd_mux : 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // working register, flags, bank select
  // ----------------------------------------
  // core updates win over a software write in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      working_reg_reg <= 8'h00;
    end else if (go_seq && is_and_work_with_file && !w[9]) begin
      working_reg_reg <= and_res; // [RULE2] [RULE4]
    end else if (go_seq && is_ret && w[0]) begin
      working_reg_reg <= shadow_work_reg; // [RULE7]
    end else if (sw_wr && wr_addr_reg == OFS_WORK) begin
      working_reg_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_reg <= '0;
    end else if (go_seq && is_and_work_with_file) begin
      flags_reg.n <= and_res[7]; // [RULE4] [RULE13]
      flags_reg.z <= (and_res == 8'h00); // [RULE4] [RULE13]
    end else if (go_seq && is_ret && w[0]) begin
      flags_reg <= shadow_flags_reg; // [RULE7]
    end else if (sw_wr && wr_addr_reg == OFS_STATUS) begin
      flags_reg <= hwdata[4:0]; // [RULE13]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bank_select_reg <= 4'h0;
    end else if (go_seq && is_ret && w[0]) begin
      bank_select_reg <= shadow_bank_reg; // [RULE7]
    end else if (sw_wr && wr_addr_reg == OFS_BANK) begin
      bank_select_reg <= hwdata[3:0];
    end
  end

  // shadows only move when the fast bit is set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shadow_work_reg  <= 8'h00;
      shadow_flags_reg <= '0;
      shadow_bank_reg  <= 4'h0;
    end else if (go_seq && is_call && w[8]) begin
      shadow_work_reg  <= working_reg_reg; // [RULE7]
      shadow_flags_reg <= flags_reg;
      shadow_bank_reg  <= bank_select_reg;
    end
  end

  // data memory is not reset; contents are software's concern
  always_ff @(posedge clk) begin
    if (go_seq && is_and_work_with_file && w[9]) begin
      dmem[addr_now] <= and_res; // [RULE2]
    end else if (go_second && state_reg == ST_MOVFF2) begin
      dmem[w[11:0]] <= dmem[dec_reg.src_addr]; // [RULE9]
    end
  end

  // ----------------------------------------
  // table pointer and latch
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      table_pointer_reg <= 21'h000000;
    end else if (go_seq && is_tbl && w[1:0] == TBL_PREINC) begin
      table_pointer_reg <= table_pointer_reg + 21'h000001; // [RULE8]
    end else if (state_reg == ST_TBL && dec_reg.tbl_mode == TBL_POSTINC) begin
      table_pointer_reg <= table_pointer_reg + 21'h000001; // [RULE8]
    end else if (state_reg == ST_TBL && dec_reg.tbl_mode == TBL_POSTDEC) begin
      table_pointer_reg <= table_pointer_reg - 21'h000001; // [RULE8]
    end else if (sw_wr && wr_addr_reg == OFS_TABLE_POINTER) begin
      table_pointer_reg <= hwdata[20:0];
    end
  end

  // pointer settles before the second cycle, so pre-increment reads the new address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      table_latch_reg <= 8'h00;
    end else if (state_reg == ST_TBL && dec_reg.tbl_read) begin
      table_latch_reg <= prog_data; // [RULE8]
    end
  end

  assign pc            = pc_reg;
  assign table_pointer = table_pointer_reg;
  assign decoded       = dec_reg;
  assign nop_cycle     = nop_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_access_map;
    go_seq && is_and_work_with_file && !w[8] |=> decoded.file_addr[11:8] == ((decoded.file_addr[7:0] <
      ACCESS_SPLIT) ? BANK_LOW : BANK_SFR);
  endproperty
  a_access_map: assert property (p_access_map) else $error("access map wrong"); // [RULE1]

  property p_dest_work;
    go_seq && is_and_work_with_file && !w[9] |=> working_reg_reg == $past(and_res);
  endproperty
  a_dest_work: assert property (p_dest_work) else $error("and result lost"); // [RULE2]

  property p_flags_kept;
    go_seq && is_and_work_with_file |=> flags_reg.c == $past(flags_reg.c) && flags_reg.ov ==
      $past(flags_reg.ov) && flags_reg.z == ($past(and_res) == 8'h00);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("and flags wrong"); // [RULE4]

  property p_bc_taken;
    bc_taken |=> pc == $past(pc) + PC_STEP + $past(rel_off) ##1 pc == $past(pc);
  endproperty
  a_bc_taken: assert property (p_bc_taken) else $error("branch target wrong"); // [RULE5]

  property p_flush;
    bc_taken |=> nop_cycle && state_reg == ST_FLUSH ##1 !nop_cycle;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush cycle"); // [RULE14]

  property p_tbl_post;
    go_seq && is_tbl && w[1:0] == TBL_POSTINC |=> ##1
      table_pointer == $past(table_pointer, 2) + 21'h000001;
  endproperty
  a_tbl_post: assert property (p_tbl_post) else $error("post-inc wrong"); // [RULE8]

  property p_fast_save;
    go_seq && is_call && w[8] |=> shadow_work_reg == $past(working_reg_reg);
  endproperty
  a_fast_save: assert property (p_fast_save) else $error("shadow not saved"); // [RULE7]

  property p_bit_sel;
    go_seq && is_bit |=> decoded.bit_sel == $past(w[11:9]);
  endproperty
  a_bit_sel: assert property (p_bit_sel) else $error("bit field wrong"); // [RULE12]

  property p_movff;
    go_seq && is_movff |=> state_reg == ST_MOVFF2 && decoded.src_addr == $past(w[11:0]);
  endproperty
  a_movff: assert property (p_movff) else $error("move source wrong"); // [RULE9]

endmodule

// File: dv/bod_prog_mem.sv
// partner model: program memory fetch path with table read port
`timescale 1ns/10ps
module bod_prog_mem import bod_pkg::*; (
  input  wire logic        run,
  input  wire logic [20:0] pc,
  input  wire logic [20:0] table_pointer,
  output      logic        fetch_valid,
  output      logic [15:0] fetch_word,
  output      logic [7:0]  prog_data
);
  // ----------------------------------------
  // program store, filled by the bench
  // ----------------------------------------
  logic [15:0] mem [0:2047];

  initial begin
    for (int i = 0; i < 2048; i++)
      mem[i] = 16'hffff;
  end

  // ----------------------------------------
  // fetch and table ports
  // ----------------------------------------
  // stalled word shows inverted, so a stale word never looks fresh
  assign fetch_valid = run;
  assign fetch_word  = run ? mem[pc[11:1]] : ~mem[pc[11:1]];
  // address-keyed bytes, so each latch load is distinguishable
  assign prog_data   = table_pointer[7:0] ^ 8'ha5;
endmodule

// File: dv/bod_byte_op_decode_bench.sv
// self-checking bench for the byte-op and branch decoder
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch at %0t got %0h expected %0h", $time, (a), (e)); end end
module bod_byte_op_decode_bench import bod_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        run;
  logic        fetch_valid;
  logic [15:0] fetch_word;
  logic [7:0]  prog_data;
  logic [20:0] pc;
  logic [20:0] table_pointer;
  bod_dec_t    decoded;
  logic        nop_cycle;
  logic [20:0] epc;
  logic [31:0] rv;
  int          mismatches;
  int          comparisons;
  // carry in bit 8, offset below; includes both offset extremes
  logic [8:0]  bc_cases [5] = '{9'h105, 9'h1fe, 9'h005, 9'h180, 9'h17f};

  bod_byte_op_decode i_bod_byte_op_decode (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .prog_data(prog_data),
    .pc(pc), .table_pointer(table_pointer), .decoded(decoded), .nop_cycle(nop_cycle)
  );

  bod_prog_mem i_bod_prog_mem (
    .run(run), .pc(pc), .table_pointer(table_pointer),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .prog_data(prog_data)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out;
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h00000000, v);
  endtask

  // one word offered for exactly one edge; fetch stalls around it
  task automatic exec(input logic [15:0] w);
    i_bod_prog_mem.mem[epc[11:1]] = w;
    @(posedge clk);
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    #1;
    epc = epc + PC_STEP;
    `CHK(pc, epc)
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_basic;
    `CHK(pc, PC_RESET)
    rd(OFS_PC, rv);
    `CHK(rv, 32'h00000000)
    wr(8'h18, 32'hffffffff);
    rd(8'h18, rv);
    `CHK(rv, 32'h00000000)
    wr(OFS_PC, 32'h00001234);
    rd(OFS_PC, rv);
    `CHK(rv, 32'h00000000)
    wr(OFS_WORK, 32'h000001a5);
    rd(OFS_WORK, rv);
    `CHK(rv, 32'h000000a5)
  endtask

  // zero-valued data only: data memory powers up unknown
  task automatic t_and;
    wr(OFS_BANK, 32'h00000003);
    wr(OFS_WORK, 32'h00000000);
    wr(OFS_STATUS, 32'h0000001b);
    exec(16'h1620);
    `CHK(decoded.file_addr, 12'h020)
    `CHK(decoded.dest_file, 1'b1)
    rd(OFS_STATUS, rv);
    `CHK(rv, 32'h0000000f)
    wr(OFS_WORK, 32'h000000ff);
    wr(OFS_BANK, 32'h00000000);
    exec(16'h1720);
    rd(OFS_WORK, rv);
    `CHK(rv, 32'h000000ff)
    exec(16'h1520);
    rd(OFS_WORK, rv);
    `CHK(rv, 32'h00000000)
    wr(OFS_BANK, 32'h00000003);
    exec(16'h1570);
    `CHK(decoded.file_addr, 12'h370)
    exec(16'h1470);
    `CHK(decoded.file_addr, 12'hf70)
    `CHK(decoded.dest_file, 1'b0)
  endtask

  task automatic t_branch;
    logic [20:0] tgt;
    logic [20:0] rel;
    logic [7:0]  n;
    logic        c;
    for (int i = 0; i < 5; i++) begin
      c = bc_cases[i][8];
      n = bc_cases[i][7:0];
      wr(OFS_STATUS, {31'h00000000, c});
      rel = epc + PC_STEP + {{12{n[7]}}, n, 1'b0};
      tgt = c ? rel : epc + PC_STEP;
      i_bod_prog_mem.mem[epc[11:1]] = {8'he2, n};
      i_bod_prog_mem.mem[tgt[11:1]] = 16'h0e77;
      @(posedge clk);
      run <= 1'b1;
      @(posedge clk);
      if (!c)
        run <= 1'b0;
      #1;
      `CHK(pc, tgt)
      `CHK(nop_cycle, c)
      `CHK(decoded.target, rel)
      if (c) begin
        @(posedge clk);
        run <= 1'b0;
        #1;
        `CHK(pc, tgt)
        `CHK(nop_cycle, 1'b0)
      end
      epc = tgt;
    end
  endtask

  // pointer at the top of its range, so increments wrap
  task automatic t_table;
    logic [20:0] tp;
    logic [20:0] ad;
    logic [7:0]  lat;
    lat = 8'h00;
    for (int m = 0; m < 8; m++) begin
      wr(OFS_TABLE_POINTER, 32'h001fffff);
      exec(16'h0008 + 16'(m));
      `CHK(nop_cycle, 1'b1)
      `CHK(decoded.tbl_mode, m[1:0])
      `CHK(decoded.tbl_read, (m < 4))
      ad = (m[1:0] == TBL_PREINC) ? 21'h000000 : 21'h1fffff;
      tp = (m[1:0] == TBL_POSTDEC) ? 21'h1ffffe :
           ((m[1:0] == TBL_NONE) ? 21'h1fffff : 21'h000000);
      if (m < 4)
        lat = ad[7:0] ^ 8'ha5;
      @(posedge clk);
      #1;
      `CHK(table_pointer, tp)
      rd(OFS_TBLLAT, rv);
      `CHK(rv, {24'h000000, lat})
    end
  endtask

  task automatic t_fields;
    exec(16'h0e77);
    `CHK(decoded.literal, 20'h00077)
    `CHK(decoded.lit_width, LIT_8)
    exec(16'h9a20);
    `CHK(decoded.bit_sel, 3'h5)
    exec(16'hc123);
    exec(16'hf456);
    `CHK(decoded.src_addr, 12'h123)
    `CHK(decoded.dst_addr, 12'h456)
    exec(16'heb85);
    exec(16'hf07a);
    `CHK(decoded.src_off, 7'h05)
    `CHK(decoded.dst_off, 7'h7a)
    exec(16'hee25);
    `CHK(decoded.fsr_sel, 2'h2)
    `CHK(decoded.lit_width, LIT_12)
    exec(16'hf000);
    // fast call saves working_reg; plain return keeps it, fast return restores it
    wr(OFS_WORK, 32'h0000003c);
    exec(16'hed00);
    `CHK(decoded.fast_sel, 1'b1)
    `CHK(decoded.lit_width, LIT_20)
    exec(16'hf000);
    wr(OFS_WORK, 32'h000000c3);
    exec(16'h0012);
    `CHK(decoded.fast_sel, 1'b0)
    rd(OFS_WORK, rv);
    `CHK(rv, 32'h000000c3)
    exec(16'h0013);
    rd(OFS_WORK, rv);
    `CHK(rv, 32'h0000003c)
    exec(16'hef34);
    `CHK(decoded.target, 21'h000068)
    `CHK(decoded.lit_width, LIT_20)
    exec(16'hf000);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset       = 1'b1;
    hsel        = 1'b0;
    haddr       = 32'h00000000;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h00000000;
    run         = 1'b0;
    epc         = PC_RESET;
    mismatches  = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_basic();
    t_and();
    t_branch();
    t_table();
    t_fields();
    close_out();
  end
endmodule
